// file: rtl/bnbx_exec.sv
/*
  Execution datapath for nibble rotates, decimal adjust and single-bit
  operations. One operation is taken at a time; results are held until the
  next one. Assumes the CPU presents the operand byte on mem_rdata_i with the
  start strobe and writes mem_wdata_o back when mem_we_o pulses.
*/
//
// Overview of operation
// - Rotate right nibbles through accumulator and memory.
// - Rotate left nibbles through accumulator and memory.
// - Decimal adjust after add; flags; four cycles.
// - Decimal adjust after subtract; flags; four cycles.
// - Move a bit to or from carry.
// - Carry becomes carry AND operand bit.
// - Carry becomes carry OR operand bit.
// - Carry becomes carry XOR operand bit.
// - Force operand bit one or zero.
// - Set, clear, complement carry in two cycles.
// - Fast count for high-speed RAM or none.
// - Slow count elsewhere; always for SFRs except nibble rotates.
// - Counts are CPU clock periods.
`timescale 1ns/1ps
module bnbx_exec
  import bnbx_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 ce_i,
  input  wire logic                 start_i,
  input  wire bnbx_pkg::bnbx_op_e   op_i,
  input  wire bnbx_pkg::bnbx_form_e form_i,
  input  wire logic [2:0]           bit_i,
  input  wire logic                 hs_ram_i,
  input  wire logic [7:0]           acc_i,
  input  wire logic [7:0]           psw_i,
  input  wire logic [7:0]           mem_rdata_i,
  output logic                      busy_o,
  output logic                      done_o,
  output logic [7:0]                acc_o,
  output logic [7:0]                psw_o,
  output logic [7:0]                mem_wdata_o,
  output logic                      mem_we_o
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [7:0] bit_put(input logic [7:0] b, input logic [2:0] idx, input logic v);
    logic [7:0] r;
    r      = b;
    r[idx] = v;
    return r;
  endfunction : bit_put

  bnbx_state_s s_q;
  bnbx_state_s s_d;
  logic        take;
  logic        cy;
  logic        opnd;
  logic        wr_en;
  logic        wr_val;
  logic [7:0]  bcd_res;
  logic        bcd_ac;
  logic        bcd_cy;

  assign take = ce_i && start_i && (s_q.st == ST_IDLE);
  assign cy   = psw_i[PSW_CY_POS];

  bnbx_bcd u_bcd (
    .sub_i (op_i == OP_DECIMAL_ADJUST_SUB),
    .acc_i (acc_i),
    .ac_i  (psw_i[PSW_AC_POS]),
    .cy_i  (cy),
    .res_o (bcd_res),
    .ac_o  (bcd_ac),
    .cy_o  (bcd_cy)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_d    = s_q;
    wr_en  = 1'b0;
    wr_val = 1'b0;
    case (form_i)
      FORM_ACC: opnd = acc_i[bit_i];
      FORM_PSW: opnd = psw_i[bit_i];
      default:  opnd = mem_rdata_i[bit_i];
    endcase
    if (ce_i) begin
      case (s_q.st)
        ST_IDLE: begin
          if (start_i) begin
            s_d.st    = ST_RUN;
            s_d.cnt   = bnbx_cycles(op_i, form_i, hs_ram_i);
            s_d.acc   = acc_i;
            s_d.program_status_word   = psw_i;
            s_d.wdata = mem_rdata_i;
            s_d.we    = 1'b0;
            case (op_i)
              OP_NIBBLE_ROTATE_RIGHT: begin
                s_d.acc   = {acc_i[7:4], mem_rdata_i[3:0]};
                s_d.wdata = {acc_i[3:0], mem_rdata_i[7:4]};
                s_d.we    = 1'b1;
              end
              OP_NIBBLE_ROTATE_LEFT: begin
                s_d.acc   = {acc_i[7:4], mem_rdata_i[7:4]};
                s_d.wdata = {mem_rdata_i[3:0], acc_i[3:0]};
                s_d.we    = 1'b1;
              end
              OP_DECIMAL_ADJUST_ADD, OP_DECIMAL_ADJUST_SUB: begin
                s_d.acc             = bcd_res;
                s_d.program_status_word[PSW_Z_POS]  = (bcd_res == 8'h00);
                s_d.program_status_word[PSW_AC_POS] = bcd_ac;
                s_d.program_status_word[PSW_CY_POS] = bcd_cy;
              end
              OP_BIT_MOVE_TO_CARRY:   s_d.program_status_word[PSW_CY_POS] = opnd;
              OP_BIT_AND_CARRY:       s_d.program_status_word[PSW_CY_POS] = cy & opnd;
              OP_BIT_OR_CARRY:        s_d.program_status_word[PSW_CY_POS] = cy | opnd;
              OP_BIT_XOR_CARRY:       s_d.program_status_word[PSW_CY_POS] = cy ^ opnd;
              OP_BIT_MOVE_FROM_CARRY: begin
                wr_en  = 1'b1;
                wr_val = cy;
              end
              OP_BIT_FORCE_ONE: begin
                wr_en  = 1'b1;
                wr_val = 1'b1;
              end
              OP_BIT_FORCE_ZERO:      wr_en = 1'b1;
              OP_CARRY_FORCE_ONE:     s_d.program_status_word[PSW_CY_POS] = 1'b1;
              OP_CARRY_FORCE_ZERO:    s_d.program_status_word[PSW_CY_POS] = 1'b0;
              OP_CARRY_COMPLEMENT:    s_d.program_status_word[PSW_CY_POS] = ~cy;
              default:                s_d.we = 1'b0;
            endcase
            // A status word target rewrites the whole word, so its flags follow the written bit.
            if (wr_en) begin
              case (form_i)
                FORM_ACC: s_d.acc = bit_put(acc_i, bit_i, wr_val);
                FORM_PSW: s_d.program_status_word = bit_put(psw_i, bit_i, wr_val);
                default: begin
                  s_d.wdata = bit_put(mem_rdata_i, bit_i, wr_val);
                  s_d.we    = 1'b1;
                end
              endcase
            end
          end
        end
        ST_RUN: begin
          s_d.cnt = s_q.cnt - CYC_ONE;
          if (s_q.cnt == CYC_ONE) begin
            s_d.st = ST_IDLE;
          end
        end
        default: s_d = STATE_RST;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Done is held back while the clock enable is low, so a frozen CPU never sees a half-counted instruction end.
  assign busy_o      = (s_q.st == ST_RUN);
  assign done_o      = busy_o && (s_q.cnt == CYC_ONE) && ce_i;
  assign mem_we_o    = done_o && s_q.we;
  assign acc_o       = s_q.acc;
  assign psw_o       = s_q.program_status_word;
  assign mem_wdata_o = s_q.wdata;

  ////////////////////////////////////////////////////////////////////////////

  logic [3:0] run_len_q;
  bnbx_op_e   op_q;
  bnbx_form_e form_q;
  logic       hs_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_len_q <= 4'h0;
      op_q      <= OP_NIBBLE_ROTATE_RIGHT;
      form_q    <= FORM_SADDR;
      hs_q      <= 1'b0;
    end else if (take) begin
      run_len_q <= 4'h0;
      op_q      <= op_i;
      form_q    <= form_i;
      hs_q      <= hs_ram_i;
    end else if (ce_i && busy_o) begin
      run_len_q <= run_len_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_take(bnbx_op_e op);
    take && (op_i == op);
  endsequence

  sequence s_finish;
    done_o ##1 !busy_o;
  endsequence

  property p_ror;
    s_take(OP_NIBBLE_ROTATE_RIGHT) |=> acc_o[3:0] == $past(mem_rdata_i[3:0])
      && mem_wdata_o == {$past(acc_i[3:0]), $past(mem_rdata_i[7:4])};
  endproperty
  a_ror: assert property (p_ror) else $error("Right nibble rotate result wrong.");

  property p_rol;
    s_take(OP_NIBBLE_ROTATE_LEFT) |=> acc_o == {$past(acc_i[7:4]), $past(mem_rdata_i[7:4])}
      && mem_wdata_o == {$past(mem_rdata_i[3:0]), $past(acc_i[3:0])};
  endproperty
  a_rol: assert property (p_rol) else $error("Left nibble rotate result wrong.");

  property p_adj;
    (done_o && (op_q == OP_DECIMAL_ADJUST_ADD || op_q == OP_DECIMAL_ADJUST_SUB))
      |-> run_len_q == 4'h3 && psw_o[PSW_Z_POS] == (acc_o == 8'h00) ##0 s_finish;
  endproperty
  a_adj: assert property (p_adj) else $error("Decimal adjust timing or zero flag wrong.");

  property p_move;
    s_take(OP_BIT_MOVE_TO_CARRY) |=> psw_o[PSW_CY_POS] == $past(opnd) && acc_o == $past(acc_i);
  endproperty
  a_move: assert property (p_move) else $error("Bit move into carry wrong.");

  property p_and;
    s_take(OP_BIT_AND_CARRY) |=> psw_o == bit_put($past(psw_i), 3'(PSW_CY_POS), $past(cy & opnd)) && !s_q.we;
  endproperty
  a_and: assert property (p_and) else $error("Bit AND altered more than carry.");

  property p_or;
    s_take(OP_BIT_OR_CARRY) |=> psw_o == bit_put($past(psw_i), 3'(PSW_CY_POS), $past(cy | opnd));
  endproperty
  a_or: assert property (p_or) else $error("Bit OR altered more than carry.");

  property p_xor;
    s_take(OP_BIT_XOR_CARRY) |=> psw_o == bit_put($past(psw_i), 3'(PSW_CY_POS), $past(cy ^ opnd));
  endproperty
  a_xor: assert property (p_xor) else $error("Bit XOR altered more than carry.");

  property p_force;
    (take && op_i == OP_BIT_FORCE_ONE && form_i == FORM_ACC) |=> (acc_o[$past(bit_i)] && busy_o) [*4] ##1 !busy_o;
  endproperty
  a_force: assert property (p_force) else $error("Forced accumulator bit or its timing wrong.");

  property p_carry_ops;
    (done_o && (op_q == OP_CARRY_FORCE_ONE || op_q == OP_CARRY_FORCE_ZERO || op_q == OP_CARRY_COMPLEMENT))
      |-> run_len_q == 4'h1;
  endproperty
  a_carry_ops: assert property (p_carry_ops) else $error("Carry operation did not take two cycles.");

  property p_fast;
    (done_o && hs_q && op_q == OP_NIBBLE_ROTATE_RIGHT) |-> run_len_q == 4'h9;
  endproperty
  a_fast: assert property (p_fast) else $error("Fast RAM nibble rotate not ten cycles.");

  property p_slow;
    (done_o && form_q == FORM_SFR && op_q >= OP_BIT_MOVE_TO_CARRY && op_q <= OP_BIT_FORCE_ZERO)
      |-> (run_len_q == 4'h6 || run_len_q == 4'h7);
  endproperty
  a_slow: assert property (p_slow) else $error("Special register bit form not on slow count.");

  property p_rmw;
    (take && op_i == OP_BIT_MOVE_FROM_CARRY && form_i == FORM_PTR) |=>
      ((mem_wdata_o ^ $past(mem_rdata_i)) & ~(8'h01 << $past(bit_i))) == 8'h00
      && mem_wdata_o[$past(bit_i)] == $past(cy) && s_q.we;
  endproperty
  a_rmw: assert property (p_rmw) else $error("Byte write touched other bits.");

endmodule : bnbx_exec

// file: shared/bnbx_pkg.sv
/*
  Shared definitions for the bit, nibble and decimal-adjust execution block:
  operation and operand-form codes, status word bit positions, cycle counts,
  the block's state record and the cycle-count lookup.
  Assumes an 8-bit accumulator and status word presented by the surrounding CPU.
*/
package bnbx_pkg;

  typedef logic [3:0] bnbx_cyc_t;

  typedef enum logic [3:0] {
    OP_NIBBLE_ROTATE_RIGHT,
    OP_NIBBLE_ROTATE_LEFT,
    OP_DECIMAL_ADJUST_ADD,
    OP_DECIMAL_ADJUST_SUB,
    OP_BIT_MOVE_TO_CARRY,
    OP_BIT_MOVE_FROM_CARRY,
    OP_BIT_AND_CARRY,
    OP_BIT_OR_CARRY,
    OP_BIT_XOR_CARRY,
    OP_BIT_FORCE_ONE,
    OP_BIT_FORCE_ZERO,
    OP_CARRY_FORCE_ONE,
    OP_CARRY_FORCE_ZERO,
    OP_CARRY_COMPLEMENT
  } bnbx_op_e;

  typedef enum logic [2:0] {
    FORM_SADDR,
    FORM_SFR,
    FORM_ACC,
    FORM_PSW,
    FORM_PTR
  } bnbx_form_e;

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } bnbx_st_e;

  // Status word bit positions.
  localparam int unsigned PSW_Z_POS  = 6;
  localparam int unsigned PSW_AC_POS = 4;
  localparam int unsigned PSW_CY_POS = 0;

  // Cycle counts in CPU clock periods.
  localparam bnbx_cyc_t CYC_ONE          = 4'h1;
  localparam bnbx_cyc_t CYC_CARRY        = 4'h2;
  localparam bnbx_cyc_t CYC_ADJ          = 4'h4;
  localparam bnbx_cyc_t CYC_ACC          = 4'h4;
  localparam bnbx_cyc_t CYC_NIB_FAST     = 4'ha;
  localparam bnbx_cyc_t CYC_NIB_SLOW     = 4'hc;
  localparam bnbx_cyc_t CYC_RD_FAST      = 4'h6;
  localparam bnbx_cyc_t CYC_RD_SLOW      = 4'h7;
  localparam bnbx_cyc_t CYC_WR_FAST      = 4'h6;
  localparam bnbx_cyc_t CYC_WR_SLOW      = 4'h8;
  localparam bnbx_cyc_t CYC_SET_SA_FAST  = 4'h4;
  localparam bnbx_cyc_t CYC_SET_SA_SLOW  = 4'h6;
  localparam bnbx_cyc_t CYC_SET_PSW      = 4'h6;
  localparam bnbx_cyc_t CYC_SET_SLOW     = 4'h8;

  typedef struct packed {
    bnbx_st_e   st;
    bnbx_cyc_t  cnt;
    logic [7:0] acc;
    logic [7:0] program_status_word;
    logic [7:0] wdata;
    logic       we;
  } bnbx_state_s;

  localparam bnbx_state_s STATE_RST = '{st: ST_IDLE, cnt: 4'h0, acc: 8'h00, program_status_word: 8'h00, wdata: 8'h00, we: 1'b0};

  // Status word and special function register forms never hit fast RAM, except in nibble rotates, which follow hs_ram alone.
  function automatic bnbx_cyc_t bnbx_cycles(input bnbx_op_e op, input bnbx_form_e form, input logic hs_ram);
    logic fast;
    fast = hs_ram && (form == FORM_SADDR || form == FORM_PTR);
    case (op)
      OP_NIBBLE_ROTATE_RIGHT, OP_NIBBLE_ROTATE_LEFT: bnbx_cycles = hs_ram ? CYC_NIB_FAST : CYC_NIB_SLOW;
      OP_DECIMAL_ADJUST_ADD, OP_DECIMAL_ADJUST_SUB:  bnbx_cycles = CYC_ADJ;
      OP_CARRY_FORCE_ONE, OP_CARRY_FORCE_ZERO, OP_CARRY_COMPLEMENT: bnbx_cycles = CYC_CARRY;
      OP_BIT_MOVE_FROM_CARRY: begin
        bnbx_cycles = (form == FORM_ACC) ? CYC_ACC : (fast ? CYC_WR_FAST : CYC_WR_SLOW);
      end
      OP_BIT_FORCE_ONE, OP_BIT_FORCE_ZERO: begin
        case (form)
          FORM_ACC:   bnbx_cycles = CYC_ACC;
          FORM_PSW:   bnbx_cycles = CYC_SET_PSW;
          FORM_SADDR: bnbx_cycles = fast ? CYC_SET_SA_FAST : CYC_SET_SA_SLOW;
          default:    bnbx_cycles = fast ? CYC_WR_FAST : CYC_SET_SLOW;
        endcase
      end
      default: begin
        bnbx_cycles = (form == FORM_ACC) ? CYC_ACC : (fast ? CYC_RD_FAST : CYC_RD_SLOW);
      end
    endcase
  endfunction : bnbx_cycles

endpackage : bnbx_pkg

// file: rtl/bnbx_bcd.sv
/*
  Decimal adjust of the accumulator after a packed BCD add or subtract.
  Purely combinational; assumes the accumulator and flags come from the
  preceding binary add or subtract.
*/
`timescale 1ns/1ps
module bnbx_bcd (
  input  wire logic       sub_i,
  input  wire logic [7:0] acc_i,
  input  wire logic       ac_i,
  input  wire logic       cy_i,
  output logic      [7:0] res_o,
  output logic            ac_o,
  output logic            cy_o
);

  logic       lo_fix;
  logic       hi_fix;
  logic [7:0] adj;

  // After a subtract a nibble can only be out of range through a borrow, so only the flags steer it.
  always_comb begin
    lo_fix = ac_i | (!sub_i && (acc_i[3:0] > 4'h9));
    hi_fix = cy_i | (!sub_i && (acc_i > 8'h99));
    adj    = {(hi_fix ? 4'h6 : 4'h0), (lo_fix ? 4'h6 : 4'h0)};
    res_o  = sub_i ? acc_i - adj : acc_i + adj;
    ac_o   = sub_i ? (lo_fix && (acc_i[3:0] < 4'h6)) : (lo_fix && (acc_i[3:0] > 4'h9));
    cy_o   = hi_fix;
  end

endmodule : bnbx_bcd

// file: tb/bnbx_tb.sv
/*
  Self-checking testbench for bnbx_exec: nibble rotates, decimal adjust,
  bit operations through carry, bit force and carry operations.
  Assumes the bnbx_pkg codes and the hand-over timing: take on a rising edge
  with ce_i high and busy_o low, done_o in the Nth enabled cycle.
*/
`timescale 1ns/1ps
module testbench;
  import bnbx_pkg::*;
  logic       clk_i       = 1'b0;
  logic       arst_n_i    = 1'b0;
  logic       ce_i        = 1'b1;
  logic       start_i     = 1'b0;
  bnbx_op_e   op_i        = OP_CARRY_COMPLEMENT;
  bnbx_form_e form_i      = FORM_ACC;
  logic [2:0] bit_i       = 3'h0;
  logic       hs_ram_i    = 1'b0;
  logic [7:0] acc_i       = 8'h00;
  logic [7:0] psw_i       = 8'h00;
  logic [7:0] mem_rdata_i = 8'h00;
  logic       busy_o, done_o, mem_we_o;
  logic [7:0] acc_o, psw_o, mem_wdata_o;
  int         bad_count   = 0;
  int         n_compared  = 0;

  always #50 clk_i = ~clk_i;

  bnbx_exec dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .start_i(start_i), .op_i(op_i),
    .form_i(form_i), .bit_i(bit_i), .hs_ram_i(hs_ram_i), .acc_i(acc_i), .psw_i(psw_i),
    .mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .done_o(done_o), .acc_o(acc_o), .psw_o(psw_o),
    .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o));

  ////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] setb(input logic [7:0] v, input logic [2:0] b, input logic x);
    setb    = v;
    setb[b] = x;
  endfunction : setb

  // One operation from take to done; ce_i is dropped for stall cycles and a
  // refused start with altered operands is offered while busy when poke is set.
  task run(input bnbx_op_e op, input bnbx_form_e f, input logic [2:0] b, input logic hs, input logic [7:0] a,
           input logic [7:0] p, input logic [7:0] m, input int stall, input logic poke, input logic [7:0] ea,
           input logic [7:0] ep, input logic [7:0] ew, input logic ewe, input int en);
    int   k;
    logic fin;
    chk({7'h0, busy_o}, 8'h00);
    op_i = op; form_i = f; bit_i = b; hs_ram_i = hs;
    acc_i = a; psw_i = p; mem_rdata_i = m; ce_i = 1'b1; start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    #1;
    chk({7'h0, busy_o}, 8'h01);
    k   = 0;
    fin = 1'b0;
    for (int t = 1; t < 40 && !fin; t++) begin
      ce_i = !(t >= 3 && t < 3 + stall);
      if (poke && t == 2) begin
        start_i = 1'b1; acc_i = ~a; mem_rdata_i = ~m;
      end
      if (poke && t == 3) begin
        start_i = 1'b0; acc_i = a; mem_rdata_i = m;
      end
      #1;
      if (ce_i) k++;
      if (done_o === 1'b1) begin
        fin = 1'b1;
        chk(8'(k), 8'(en));
        chk(acc_o, ea);
        chk(psw_o, ep);
        if (ewe !== 1'bx) chk({7'h0, mem_we_o}, {7'h0, ewe});
        if (ewe === 1'b1) chk(mem_wdata_o, ew);
      end else if (mem_we_o === 1'b1) begin
        bad_count++;
        $display("Error at %0t: write strobe outside done", $time);
      end
      @(negedge clk_i);
    end
    ce_i = 1'b1;
    if (!fin) begin
      bad_count++;
      $display("Error at %0t: no done", $time);
    end
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #1_000_000;
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    bnbx_op_e   rd_ops [4];
    bnbx_op_e   wr_ops [3];
    bnbx_op_e   cy_ops [3];
    bnbx_form_e fm;
    logic [7:0] a, p, m, src, nb;
    logic [2:0] b;
    logic       c, hs, ob, r, x, fast;
    int         n;
    rd_ops = '{OP_BIT_MOVE_TO_CARRY, OP_BIT_AND_CARRY, OP_BIT_OR_CARRY, OP_BIT_XOR_CARRY};
    wr_ops = '{OP_BIT_MOVE_FROM_CARRY, OP_BIT_FORCE_ONE, OP_BIT_FORCE_ZERO};
    cy_ops = '{OP_CARRY_FORCE_ONE, OP_CARRY_FORCE_ZERO, OP_CARRY_COMPLEMENT};
    repeat (4) @(negedge clk_i);
    chk({busy_o, done_o, mem_we_o, 5'h0}, 8'h00);
    chk(acc_o | psw_o | mem_wdata_o, 8'h00);
    arst_n_i = 1'b1;
    // Nibble rotates, fast and slow, with a refused start and a ce stall.
    run(OP_NIBBLE_ROTATE_RIGHT, FORM_PTR, 3'h0, 1'b1, 8'h12, 8'h00, 8'h34, 0, 1'b1, 8'h14, 8'h00, 8'h23, 1'b1, 10);
    run(OP_NIBBLE_ROTATE_RIGHT, FORM_PTR, 3'h0, 1'b0, 8'hab, 8'h00, 8'hcd, 3, 1'b0, 8'had, 8'h00, 8'hbc, 1'b1, 12);
    run(OP_NIBBLE_ROTATE_LEFT, FORM_PTR, 3'h0, 1'b1, 8'h12, 8'h00, 8'h34, 0, 1'b0, 8'h13, 8'h00, 8'h42, 1'b1, 10);
    run(OP_NIBBLE_ROTATE_LEFT, FORM_PTR, 3'h0, 1'b0, 8'hf9, 8'h00, 8'h6e, 2, 1'b1, 8'hf6, 8'h00, 8'he9, 1'b1, 12);
    // Decimal adjust, including the wrap to zero and a kept borrow.
    run(OP_DECIMAL_ADJUST_ADD, FORM_ACC, 3'h0, 1'b1, 8'h7d, 8'h02, 8'h00, 0, 1'b1, 8'h83, 8'h12, 8'h00, 1'b0, 4);
    run(OP_DECIMAL_ADJUST_ADD, FORM_ACC, 3'h0, 1'b1, 8'h9a, 8'h02, 8'h00, 0, 1'b0, 8'h00, 8'h53, 8'h00, 1'b0, 4);
    run(OP_DECIMAL_ADJUST_SUB, FORM_ACC, 3'h0, 1'b1, 8'h2d, 8'h12, 8'h00, 0, 1'b0, 8'h27, 8'h02, 8'h00, 1'b0, 4);
    run(OP_DECIMAL_ADJUST_SUB, FORM_ACC, 3'h0, 1'b1, 8'hd3, 8'h03, 8'h00, 1, 1'b0, 8'h73, 8'h03, 8'h00, 1'b0, 4);
    // Reads of a bit into carry over every form, carry low and high.
    for (int i = 0; i < 4; i++)
      for (int f = 0; f < 5; f++)
        for (int ci = 0; ci < 2; ci++) begin
          fm  = bnbx_form_e'(f);
          c   = ci[0];
          b   = 3'(f * 2 + ci + 1);
          hs  = 1'((i + f + ci) % 2);
          a   = 8'h5a ^ 8'(i * 16 + f);
          p   = 8'h22 | {7'h0, c};
          m   = 8'hc3 ^ 8'(f * 8 + ci);
          src = (fm == FORM_ACC) ? a : (fm == FORM_PSW) ? p : m;
          ob  = src[b];
          r   = (i == 0) ? ob : (i == 1) ? (c & ob) : (i == 2) ? (c | ob) : (c ^ ob);
          fast = hs && (fm == FORM_SADDR || fm == FORM_PTR);
          n   = (fm == FORM_ACC) ? 4 : (fast ? 6 : 7);
          run(rd_ops[i], fm, b, hs, a, p, m, 0, 1'b0, a, setb(p, 3'h0, r), 8'h00, 1'b0, n);
        end
    // Byte writes of one bit over every form; the other seven bits must stay.
    for (int i = 0; i < 3; i++)
      for (int f = 0; f < 5; f++)
        for (int ci = 0; ci < 2; ci++) begin
          fm  = bnbx_form_e'(f);
          c   = ci[0];
          b   = 3'(7 - f - ci);
          hs  = 1'((i + ci) % 2);
          a   = 8'h96 ^ 8'(f * 17 + ci);
          p   = 8'h54 | {7'h0, c};
          m   = 8'h3c ^ 8'(i * 64 + f * 5 + ci * 128);
          src = (fm == FORM_ACC) ? a : (fm == FORM_PSW) ? p : m;
          x   = (i == 0) ? c : (i == 1);
          nb  = setb(src, b, x);
          fast = hs && (fm == FORM_SADDR || fm == FORM_PTR);
          if (fm == FORM_ACC) n = 4;
          else if (i == 0) n = fast ? 6 : 8;
          else if (fm == FORM_PSW) n = 6;
          else if (fm == FORM_SADDR) n = fast ? 4 : 6;
          else n = fast ? 6 : 8;
          run(wr_ops[i], fm, b, hs, a, p, m, 0, 1'b0, (fm == FORM_ACC) ? nb : a, (fm == FORM_PSW) ? nb : p,
              nb, (fm == FORM_ACC) ? 1'b0 : (fm == FORM_PSW) ? 1'bx : 1'b1, n);
        end
    // Carry set, clear and complement back to back from both carry values.
    for (int i = 0; i < 3; i++)
      for (int ci = 0; ci < 2; ci++) begin
        p = 8'ha4 | 8'(ci);
        r = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : ~ci[0];
        run(cy_ops[i], FORM_ACC, 3'h0, 1'b0, 8'h11, p, 8'h00, 0, 1'b0, 8'h11, setb(p, 3'h0, r), 8'h00, 1'b0, 2);
      end
    end_of_test();
  end
endmodule : testbench
